// >>> inc/rsci_map.svh
// Constants for the radio serial command interpreter: opcodes, field positions, reset values.
// Assumes it is included by the package and the design file by its bare name.
// Operation
// - Unmasked set status flag drives interrupt low.
// - Host writes one to clear; interrupt then releases.
// - Config mask bits block sources; reset clears masks.
// - Pipe field updates at interrupt falling transition.
// - Status shifts out during command byte.
// - Command is one byte, MSB first.
// - Data LSB byte first; bank1 regs 0-8 reversed.
// - 000AAAAA reads register, one to five bytes.
// - 001AAAAA writes register, only in standby.
// - 0x61 reads oldest payload, then removes it.
// - 0xa0 loads transmit payload from byte zero.
// - 0xe1 with no data empties transmit FIFO.
// - 0xe3 repeats payload until 0xa0 load or flush.
// - 0x50 then 0x73 toggles optional features.
// - Features start disabled; disabled access reads zero.
// - 0x50 then 0x53 toggles bank, status bit7.
// - 0x60 returns width of head receive payload.
// - 0xa8-0xad loads acknowledge payload for pipe.
// - 0xb0 loads payload without acknowledge request.
// - 0xff does nothing but returns status.
`ifndef RSCI_MAP_SVH
`define RSCI_MAP_SVH
`define RSCI_LAST_BIT 3'h7
`define RSCI_CNT_MAX 6'h3f
`define RSCI_CMD_RD_REG 3'h0
`define RSCI_CMD_WR_REG 3'h1
`define RSCI_CMD_RX_READ 8'h61
`define RSCI_CMD_RX_WIDTH 8'h60
`define RSCI_CMD_TX_LOAD 8'ha0
`define RSCI_CMD_TX_UNACKED 8'hb0
`define RSCI_CMD_ACK_LOAD 5'h15
`define RSCI_CMD_TX_FLUSH 8'he1
`define RSCI_CMD_TX_REPEAT 8'he3
`define RSCI_CMD_ACTIVATE 8'h50
`define RSCI_CMD_NOP 8'hff
`define RSCI_KEY_FEATURES 8'h73
`define RSCI_KEY_BANK 8'h53
`define RSCI_PIPE_MAX 3'h5
`define RSCI_ADDR_CONFIG 5'h00
`define RSCI_ADDR_STATUS 5'h07
`define RSCI_BANK1_REV_LAST 5'h08
`define RSCI_CFG_MASK_MSB 6
`define RSCI_CFG_MASK_LSB 4
`define RSCI_ST_BANK 7
`define RSCI_ST_FLAG_MSB 6
`define RSCI_ST_FLAG_LSB 4
`define RSCI_ST_PIPE_MSB 3
`define RSCI_ST_PIPE_LSB 1
`define RSCI_ST_FULL 0
`define RSCI_PIPE_RST 3'h7
`define RSCI_MASK_RST 3'h0
`define RSCI_FLAGS_RST 3'h0
`endif

// >>> inc/rsci_pkg.sv
// Types shared by the radio serial command interpreter.
// Assumes the constants header sits beside it on the include path.
`include "rsci_map.svh"
package rsci_pkg;
	typedef enum logic [2:0] {
		RSCI_OP_OTHER = 3'b000,
		RSCI_OP_RD_REG = 3'b001,
		RSCI_OP_WR_REG = 3'b010,
		RSCI_OP_RX_READ = 3'b011,
		RSCI_OP_RX_WIDTH = 3'b100,
		RSCI_OP_TX_LOAD = 3'b101,
		RSCI_OP_ACK_LOAD = 3'b110,
		RSCI_OP_UNACKED = 3'b111
	} rsci_op_t;
endpackage : rsci_pkg

// >>> logic/rsci_top.sv
// Serial command interpreter and interrupt logic of a packet radio.
// Assumes a mode 0 serial master on i_sck, and that register map, FIFOs and radio
// state machine live outside; read data comes from logic clocked by i_sck.
`include "rsci_map.svh"
module rsci_top
	import rsci_pkg::*;
#(
	parameter logic [7:0] P_RX_FLUSH_CODE = 8'he2
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_sck,
	input wire logic i_select_low,
	input wire logic i_mosi,
	input wire logic [7:0] i_rd_data,
	input wire logic i_tx_done_set,
	input wire logic i_rx_ready_set,
	input wire logic i_retry_limit_set,
	input wire logic [2:0] i_rx_pipe,
	input wire logic i_tx_full,
	input wire logic i_idle_mode,
	output logic o_miso,
	output logic [7:0] o_rd_cmd,
	output logic [5:0] o_rd_count,
	output logic o_rd_rev,
	output logic o_irq_n,
	output logic [7:0] o_status,
	output logic [2:0] o_mask,
	output logic o_wr_strobe,
	output logic [4:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	output logic [5:0] o_wr_index,
	output logic o_wr_rev,
	output logic o_tx_load,
	output logic o_tx_noack,
	output logic o_ack_load,
	output logic [2:0] o_ack_pipe,
	output logic o_tx_flush,
	output logic o_rx_flush,
	output logic o_rx_pop,
	output logic o_tx_reuse,
	output logic o_feat_en,
	output logic o_bank
);

	// Link domain: everything clocked by i_sck.
	// The frame part is cleared asynchronously while select is high, so every
	// select fall starts a fresh command with no sck edge needed.
	logic link_rst;
	logic [2:0] bit_cnt;
	logic [6:0] in_sh;
	logic [5:0] byte_cnt;
	logic first_done;
	logic [2:0] neg_cnt;
	logic neg_data;
	logic [7:0] out_sh;
	logic [7:0] cmd;
	logic [7:0] data;
	logic [5:0] data_idx;
	logic ev_is_cmd;
	logic ev_tgl;

	wire byte_done = (bit_cnt == `RSCI_LAST_BIT);
	wire [7:0] full_byte = {in_sh, i_mosi};

	// Status snapshot, bank and feature state come from the core clock; the snapshot is frozen
	// for the whole frame and the other two move only after an activate data byte, so the link may read them as quasi-static.
	logic [7:0] status_snap;
	logic feat_en;
	logic bank;

	rsci_op_t link_op;
	rsci_op_t core_op;

	assign link_op = (cmd[7:5] == `RSCI_CMD_RD_REG) ? RSCI_OP_RD_REG :
		(cmd[7:5] == `RSCI_CMD_WR_REG) ? RSCI_OP_WR_REG :
		(cmd == `RSCI_CMD_RX_READ) ? RSCI_OP_RX_READ :
		(cmd == `RSCI_CMD_RX_WIDTH) ? RSCI_OP_RX_WIDTH :
		(cmd == `RSCI_CMD_TX_LOAD) ? RSCI_OP_TX_LOAD :
		(cmd[7:3] == `RSCI_CMD_ACK_LOAD) ? RSCI_OP_ACK_LOAD :
		(cmd == `RSCI_CMD_TX_UNACKED) ? RSCI_OP_UNACKED : RSCI_OP_OTHER;
	assign core_op = link_op;

	wire reg_rev = bank && (cmd[4:0] <= `RSCI_BANK1_REV_LAST);
	wire read_status = (link_op == RSCI_OP_RD_REG) && (cmd[4:0] == `RSCI_ADDR_STATUS);
	wire read_ext = (link_op == RSCI_OP_RD_REG) || (link_op == RSCI_OP_RX_READ) ||
		((link_op == RSCI_OP_RX_WIDTH) && feat_en);
	wire [7:0] rd_byte = read_status ? status_snap : (read_ext ? i_rd_data : 8'h00);

	// Bits are sampled on the rising edge, MSB first.
	always_ff @(posedge i_sck or posedge i_select_low) begin
		if (i_select_low) begin
			bit_cnt <= 3'h0;
			in_sh <= 7'h00;
			byte_cnt <= 6'h00;
			first_done <= 1'b0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			in_sh <= full_byte[6:0];
			if (byte_done && (byte_cnt != `RSCI_CNT_MAX)) begin
				byte_cnt <= byte_cnt + 6'h01;
			end
			if (byte_done) begin
				first_done <= 1'b1;
			end
		end
	end

	// Output bits change on the falling edge.
	always_ff @(negedge i_sck or posedge i_select_low) begin
		if (i_select_low) begin
			neg_cnt <= 3'h0;
			neg_data <= 1'b0;
			out_sh <= 8'h00;
		end else begin
			neg_cnt <= bit_cnt;
			neg_data <= first_done;
			if (first_done && (bit_cnt == 3'h0)) begin
				out_sh <= rd_byte;
			end else begin
				out_sh <= {out_sh[6:0], 1'b0};
			end
		end
	end

	// The byte hand-off to the core survives the end of a frame, so it is
	// reset only by the system reset, carried over as a flip-flop output.
	always_ff @(posedge i_sck or posedge link_rst) begin
		if (link_rst) begin
			cmd <= 8'h00;
			data <= 8'h00;
			data_idx <= 6'h00;
			ev_is_cmd <= 1'b0;
			ev_tgl <= 1'b0;
		end else if (byte_done) begin
			ev_tgl <= ~ev_tgl;
			ev_is_cmd <= ~first_done;
			if (!first_done) begin
				cmd <= full_byte;
			end else begin
				data <= full_byte;
				data_idx <= byte_cnt - 6'h01;
			end
		end
	end

	always_ff @(posedge i_sck or posedge link_rst) begin
		if (link_rst) begin
			o_rd_cmd <= 8'h00;
			o_rd_count <= 6'h00;
			o_rd_rev <= 1'b0;
		end else begin
			o_rd_cmd <= byte_done && !first_done ? full_byte : o_rd_cmd;
			o_rd_count <= byte_done ? byte_cnt + 6'h01 : byte_cnt;
			o_rd_rev <= reg_rev;
		end
	end

	// The first status bit must be on the pin as soon as select falls, before
	// any clock edge, so the pin is chosen between two flip-flops here.
	assign o_miso = neg_data ? out_sh[7] : status_snap[3'h7 - neg_cnt];

	// Core domain.
	logic sel_s1;
	logic sel_s2;
	logic sel_s3;
	logic ev_s1;
	logic ev_s2;
	logic ev_s3;
	logic got_data;
	logic [2:0] flags;
	logic [2:0] pipe;
	logic reuse;

	always_ff @(posedge i_ref_clk) begin
		link_rst <= i_rst;
		sel_s1 <= i_select_low;
		sel_s2 <= sel_s1;
		sel_s3 <= sel_s2;
		ev_s1 <= ev_tgl;
		ev_s2 <= ev_s1;
		ev_s3 <= ev_s2;
	end

	wire ev = ev_s2 ^ ev_s3;
	wire frame_on = !sel_s2;
	wire frame_end = sel_s2 && !sel_s3;
	wire ev_cmd = ev && ev_is_cmd;
	wire ev_data = ev && !ev_is_cmd;

	wire wr_reg = ev_data && (core_op == RSCI_OP_WR_REG) && i_idle_mode;
	wire wr_bank0 = wr_reg && !bank && (data_idx == 6'h00);
	wire clr_status = wr_bank0 && (cmd[4:0] == `RSCI_ADDR_STATUS);
	wire wr_config = wr_bank0 && (cmd[4:0] == `RSCI_ADDR_CONFIG);
	wire tx_load = ev_data && (core_op == RSCI_OP_TX_LOAD);
	wire unacked = ev_data && (core_op == RSCI_OP_UNACKED) && feat_en;
	wire ack_load = ev_data && (core_op == RSCI_OP_ACK_LOAD) && feat_en &&
		(cmd[2:0] <= `RSCI_PIPE_MAX);
	wire activate = ev_data && (cmd == `RSCI_CMD_ACTIVATE) && (data_idx == 6'h00) && i_idle_mode;
	wire tx_flush = ev_cmd && (cmd == `RSCI_CMD_TX_FLUSH);
	wire rx_flush = ev_cmd && (cmd == P_RX_FLUSH_CODE);
	wire tx_repeat = ev_cmd && (cmd == `RSCI_CMD_TX_REPEAT);
	wire [2:0] set_flags = {i_rx_ready_set, i_tx_done_set, i_retry_limit_set};
	wire [2:0] clr_flags = clr_status ? data[`RSCI_ST_FLAG_MSB:`RSCI_ST_FLAG_LSB] : 3'h0;

	// A flag that is set in the same cycle as its clear stays set.
	wire [2:0] next_flags = set_flags | (flags & ~clr_flags);
	wire [2:0] next_mask = wr_config ? data[`RSCI_CFG_MASK_MSB:`RSCI_CFG_MASK_LSB] : o_mask;
	wire next_irq_n = ~|(next_flags & ~next_mask);
	wire [2:0] next_pipe = (o_irq_n && !next_irq_n) ? i_rx_pipe : pipe;
	wire [7:0] status = {bank, flags, pipe, i_tx_full};
	// The status port is built from next values so that its flags and pipe
	// change in the same cycle as the interrupt pin and never disagree with it.
	wire [7:0] next_status = {bank, next_flags, next_pipe, i_tx_full};

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			flags <= `RSCI_FLAGS_RST;
			o_mask <= `RSCI_MASK_RST;
			pipe <= `RSCI_PIPE_RST;
			o_irq_n <= 1'b1;
		end else begin
			flags <= next_flags;
			o_mask <= next_mask;
			o_irq_n <= next_irq_n;
			pipe <= next_pipe;
		end
	end

	// The snapshot only moves between frames; a frame therefore shows the
	// status as it stood when select fell.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			status_snap <= 8'h00;
			o_status <= 8'h00;
		end else begin
			o_status <= next_status;
			if (!frame_on) begin
				status_snap <= status;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			feat_en <= 1'b0;
			bank <= 1'b0;
			reuse <= 1'b0;
			got_data <= 1'b0;
		end else begin
			if (activate && (data == `RSCI_KEY_FEATURES)) begin
				feat_en <= ~feat_en;
			end
			if (activate && (data == `RSCI_KEY_BANK)) begin
				bank <= ~bank;
			end
			if (tx_load || tx_flush) begin
				reuse <= 1'b0;
			end else if (tx_repeat) begin
				reuse <= 1'b1;
			end
			if (ev_cmd) begin
				got_data <= 1'b0;
			end else if (ev_data) begin
				got_data <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_wr_strobe <= 1'b0;
			o_wr_addr <= 5'h00;
			o_wr_data <= 8'h00;
			o_wr_index <= 6'h00;
			o_wr_rev <= 1'b0;
			o_tx_load <= 1'b0;
			o_tx_noack <= 1'b0;
			o_ack_load <= 1'b0;
			o_ack_pipe <= 3'h0;
			o_tx_flush <= 1'b0;
			o_rx_flush <= 1'b0;
			o_rx_pop <= 1'b0;
			o_tx_reuse <= 1'b0;
			o_feat_en <= 1'b0;
			o_bank <= 1'b0;
		end else begin
			o_wr_strobe <= wr_reg;
			o_tx_load <= tx_load || unacked;
			o_tx_noack <= unacked;
			o_ack_load <= ack_load;
			if (ev_data) begin
				o_wr_addr <= cmd[4:0];
				o_wr_data <= data;
				o_wr_index <= data_idx;
				o_wr_rev <= reg_rev;
				o_ack_pipe <= cmd[2:0];
			end
			o_tx_flush <= tx_flush;
			o_rx_flush <= rx_flush;
			o_rx_pop <= frame_end && got_data && (core_op == RSCI_OP_RX_READ);
			o_tx_reuse <= reuse;
			o_feat_en <= feat_en;
			o_bank <= bank;
		end
	end

endmodule : rsci_top

// >>> sim/rsci_checker.sv
// Concurrent checks on the command interpreter's core-clock ports.
// Assumes it is bound to rsci_top and sees only that module's ports.
module rsci_checker (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_tx_done_set,
	input wire logic i_rx_ready_set,
	input wire logic i_retry_limit_set,
	input wire logic i_idle_mode,
	input wire logic o_irq_n,
	input wire logic [7:0] o_status,
	input wire logic [2:0] o_mask,
	input wire logic o_wr_strobe,
	input wire logic o_tx_load,
	input wire logic o_tx_noack,
	input wire logic o_tx_flush,
	input wire logic o_tx_reuse,
	input wire logic o_feat_en,
	input wire logic o_bank
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	wire [2:0] live = o_status[6:4] & ~o_mask;
	property p_irq_set;
		(i_rx_ready_set && !o_mask[2]) || (i_tx_done_set && !o_mask[1]) || (i_retry_limit_set && !o_mask[0])
			|=> !o_irq_n;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq stayed high");
	property p_irq_hold;
		(live == 3'h0) [*3] |-> o_irq_n;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq not released");
	property p_irq_fall;
		$fell(o_irq_n) |-> live != 3'h0;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without live flag");
	property p_pipe;
		!$past(i_rst) && !$past(i_rst, 2) && $changed(o_status[3:1]) |-> $fell(o_irq_n);
	endproperty
	a_pipe: assert property (p_pipe) else $error("pipe moved outside irq fall");
	property p_wr_idle;
		o_wr_strobe |-> $past(i_idle_mode);
	endproperty
	a_wr_idle: assert property (p_wr_idle) else $error("write outside idle");
	property p_noack;
		o_tx_noack |-> o_tx_load && o_feat_en;
	endproperty
	a_noack: assert property (p_noack) else $error("bad unacked load");
	property p_reuse_end;
		o_tx_flush || (o_tx_load && !o_tx_noack) |-> ##[0:2] !o_tx_reuse;
	endproperty
	a_reuse_end: assert property (p_reuse_end) else $error("repeat not ended");
	property p_bank;
		$changed(o_bank) |-> ##[0:4] o_status[7] == o_bank;
	endproperty
	a_bank: assert property (p_bank) else $error("bank not in status");
	c_irq: cover property ($fell(o_irq_n));
	c_noack: cover property (o_tx_noack);
	c_bank: cover property ($rose(o_bank));
endmodule : rsci_checker

// >>> sim/rsci_host.sv
// Mode 0 serial host model with a 30 ns link clock that runs only inside frames.
// Assumes the bench calls frame() one at a time.
module rsci_host (
	output logic o_sck,
	output logic o_select_low,
	output logic o_mosi,
	input wire logic i_miso
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_sck = 1'b0;
		o_select_low = 1'b1;
		o_mosi = 1'b0;
	end
	task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
		o_select_low = 1'b0;
		#150;
		for (int i = 15; i >= 16 - 8 * n; i--) begin
			o_mosi = tx[i];
			#15 o_sck = 1'b1;
			rx[i] = i_miso;
			#15 o_sck = 1'b0;
			if (i % 8 == 0)
				#200;
		end
		// A released data line must not keep its last bit.
		o_mosi = ~o_mosi;
		o_select_low = 1'b1;
		#200;
	endtask : frame
endmodule : rsci_host

// >>> sim/testbench.sv
// Self-checking bench for the serial command interpreter and its interrupt pin.
// Assumes the checker and host model are compiled before it.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_ref_clk, i_rst, i_sck, i_select_low, i_mosi, i_tx_done_set, i_rx_ready_set, i_retry_limit_set;
	logic i_idle_mode, o_miso, o_irq_n, o_wr_strobe, o_tx_load, o_tx_noack, o_ack_load, o_tx_flush;
	logic o_rx_flush, o_rx_pop, o_tx_reuse, o_feat_en, o_bank, i_tx_full, o_rd_rev, o_wr_rev;
	logic [7:0] i_rd_data, o_status, o_wr_data, st, r, o_rd_cmd;
	logic [5:0] o_rd_count, o_wr_index;
	logic [2:0] i_rx_pipe, o_mask, o_ack_pipe;
	logic [4:0] o_wr_addr;
	logic [15:0] rx, q[$];
	int fails = 0;
	int n_compared = 0;
	rsci_top uut (.i_ref_clk, .i_rst, .i_sck, .i_select_low, .i_mosi, .i_rd_data, .i_tx_done_set,
		.i_rx_ready_set, .i_retry_limit_set, .i_rx_pipe, .i_tx_full, .i_idle_mode, .o_miso, .o_rd_cmd,
		.o_rd_count, .o_rd_rev, .o_irq_n, .o_status, .o_mask, .o_wr_strobe, .o_wr_addr, .o_wr_data,
		.o_wr_index, .o_wr_rev, .o_tx_load, .o_tx_noack, .o_ack_load, .o_ack_pipe, .o_tx_flush,
		.o_rx_flush, .o_rx_pop, .o_tx_reuse, .o_feat_en, .o_bank);
	rsci_host host (.o_sck(i_sck), .o_select_low(i_select_low), .o_mosi(i_mosi), .i_miso(o_miso));
	wire [15:0] seen = {o_wr_strobe, o_tx_load, o_tx_noack, o_ack_load, o_tx_flush, o_rx_flush, o_rx_pop,
		1'b0, o_wr_strobe ? o_wr_data : 8'h00};
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic cmd(input logic [15:0] tx, input int n);
		host.frame(tx, n, rx);
		check({8'h00, rx[15:8]}, {8'h00, st});
	endtask : cmd
	task automatic pulse(input logic [2:0] v);
		@(negedge i_ref_clk) {i_rx_ready_set, i_tx_done_set, i_retry_limit_set} = v;
		@(negedge i_ref_clk) {i_rx_ready_set, i_tx_done_set, i_retry_limit_set} = 3'h0;
		@(negedge i_ref_clk);
	endtask : pulse
	always @(negedge i_ref_clk)
		if (!i_rst && |seen[15:9])
			check(seen, q.size() > 0 ? q.pop_front() : 16'h0000);
	initial begin
		#100000;
		fails++;
		give_verdict();
	end
	initial begin
		r = 8'($urandom(8640)) | 8'h01;
		i_rst = 1'b1;
		{i_tx_done_set, i_rx_ready_set, i_retry_limit_set} = 3'h0;
		i_idle_mode = 1'b1;
		i_tx_full = 1'b0;
		i_rd_data = r;
		i_rx_pipe = r[2:0] % 3'h6;
		st = 8'h0e;
		repeat (5) @(negedge i_ref_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_ref_clk);
		cmd(16'hff00, 1);
		pulse(3'h4);
		st = {4'h4, i_rx_pipe, 1'b0};
		check({15'h0, o_irq_n}, 16'h0000);
		check({8'h0, o_status}, {8'h0, st});
		cmd(16'hff00, 1);
		q.push_back(16'h8040);
		cmd(16'h2740, 2);
		st[6] = 1'b0;
		check({15'h0, o_irq_n}, 16'h0001);
		q.push_back(16'h8070);
		cmd(16'h2070, 2);
		pulse(3'h2);
		st[5] = 1'b1;
		check({12'h0, o_mask, o_irq_n}, 16'h000f);
		q.push_back(16'h8020);
		cmd(16'h2720, 2);
		st[5] = 1'b0;
		q.push_back(16'h8000);
		cmd(16'h2000, 2);
		@(negedge i_ref_clk) i_idle_mode = 1'b0;
		cmd(16'h2070, 2);
		check({12'h0, o_mask, o_irq_n}, 16'h0001);
		@(negedge i_ref_clk) i_idle_mode = 1'b1;
		cmd({8'hb0, r}, 2);
		cmd(16'h6000, 2);
		check({8'h0, rx[7:0]}, 16'h0000);
		q.push_back(16'h4000);
		cmd({8'ha0, r}, 2);
		cmd(16'h5073, 2);
		check({15'h0, o_feat_en}, 16'h0001);
		cmd(16'h6000, 2);
		check({8'h0, rx[7:0]}, {8'h0, r});
		for (int p = 0; p < 8; p++) begin
			if (p < 6)
				q.push_back(16'h1000);
			cmd({5'h15, 3'(p), r}, 2);
			check({13'h0, o_ack_pipe}, 16'(p));
		end
		q.push_back(16'h6000);
		cmd({8'hb0, r}, 2);
		cmd(16'he300, 1);
		check({15'h0, o_tx_reuse}, 16'h0001);
		q.push_back(16'h4000);
		cmd({8'ha0, r}, 2);
		check({15'h0, o_tx_reuse}, 16'h0000);
		cmd(16'he300, 1);
		q.push_back(16'h0800);
		cmd(16'he100, 1);
		check({15'h0, o_tx_reuse}, 16'h0000);
		q.push_back(16'h0400);
		cmd(16'he200, 1);
		cmd(16'h0500, 2);
		check({8'h0, rx[7:0]}, {8'h0, r});
		cmd(16'h0700, 2);
		check({8'h0, rx[7:0]}, {8'h0, st});
		q.push_back(16'h0200);
		cmd(16'h6100, 2);
		check({8'h0, rx[7:0]}, {8'h0, r});
		cmd(16'h5053, 2);
		@(negedge i_ref_clk) i_tx_full = 1'b1;
		st = {1'b1, st[6:1], 1'b1};
		cmd(16'hff00, 1);
		q.push_back({8'h80, r});
		cmd({8'h21, r}, 2);
		check({4'h0, o_wr_rev, o_wr_index, o_wr_addr}, 16'h0801);
		check({1'b0, o_rd_rev, o_rd_count, o_rd_cmd}, 16'h4221);
		check(16'(q.size()), 16'h0000);
		give_verdict();
	end
endmodule : testbench
bind rsci_top rsci_checker chk (.i_ref_clk, .i_rst, .i_tx_done_set, .i_rx_ready_set, .i_retry_limit_set,
	.i_idle_mode, .o_irq_n, .o_status, .o_mask, .o_wr_strobe, .o_tx_load, .o_tx_noack, .o_tx_flush,
	.o_tx_reuse, .o_feat_en, .o_bank);
